//--- verilog/uan_params.svh
/*
  Constants of the serial ninth-bit and line control block: register
  indices, field positions, reset values and bit timing.
  Assumes it is included by bare name from each design file that uses it.
*/
`ifndef UAN_PARAMS_SVH
`define UAN_PARAMS_SVH

// ========================================
// register indices (byte address = 4 * index)
`define UAN_IDX_C3        6'h06
`define UAN_IDX_DATA      6'h07
`define UAN_IDX_CFG       6'h08
`define UAN_IDX_STAT      6'h09
`define UAN_IDX_IRQ_STS   6'h0A
`define UAN_IDX_IRQ_EN    6'h0B
`define UAN_IDX_IRQ_CLR   6'h0C

// ========================================
// serial_control_three fields
`define UAN_C3_RX9        7
`define UAN_C3_TX9        6
`define UAN_C3_DIR        5
`define UAN_C3_INV        4
`define UAN_C3_OVERRUN_IRQ_ENABLE       3

// ========================================
// configuration fields
`define UAN_CFG_NINE      0
`define UAN_CFG_LOOP      1
`define UAN_CFG_RECEIVER_SOURCE_SELECT      2

// ========================================
// interrupt status bits
`define UAN_IRQ_RX        0
`define UAN_IRQ_OVR       1
`define UAN_IRQ_TX        2
`define UAN_IRQ_W         3

// ========================================
// reset values and bus responses
`define UAN_C3_RST        8'h00
`define UAN_CFG_RST       3'h0
`define UAN_RESP_OKAY     2'h0
`define UAN_RESP_SLVERR   2'h2

// ========================================
// bit timing
`define UAN_CLK_HZ        40000000
`define UAN_BAUD_HZ       115200
`define UAN_BIT_CYC       16'(`UAN_CLK_HZ / `UAN_BAUD_HZ)
`define UAN_HALF_CYC      16'(`UAN_CLK_HZ / `UAN_BAUD_HZ / 2)

`endif

//--- verilog/uan_pkg.sv
/*
  Types of the serial ninth-bit and line control block.
  Assumes nothing of its surroundings.
*/
package uan_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uan_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uan_rx_state_t;
endpackage

//--- verilog/uan_ser_if.sv
/*
  Carrier between the register front end and the two line engines.
  Assumes one clock shared by all three modules.
*/
`timescale 1ns/1ps
interface uan_ser_if;
  logic       load;
  logic [8:0] tx_word;
  logic       nine;
  logic       busy;
  logic       tx_line;
  logic       tx_done;
  logic       rx_line;
  logic       rx_done;
  logic [8:0] rx_word;

  modport ctl (output load, tx_word, nine, rx_line,
               input busy, tx_line, tx_done, rx_done, rx_word);
  modport txp (input load, tx_word, nine, output busy, tx_line, tx_done);
  modport rxp (input nine, rx_line, output rx_done, rx_word);
endinterface

//--- verilog/uan_tx_engine.sv
/*
  Transmit shifter: start bit, 8 or 9 data bits lsb first, one stop bit.
  Assumes load is a one-cycle strobe; a load while busy is dropped.
*/
`timescale 1ns/1ps
`include "uan_params.svh"
module uan_tx_engine (
  input wire logic aclk,
  input wire logic aresetn,
  uan_ser_if.txp   lnk
);
  uan_pkg::uan_tx_state_t state_reg;
  logic [15:0]            cnt_reg;
  logic [3:0]             bit_reg;
  logic [8:0]             sh_reg;
  logic                   line_reg;
  logic                   done_reg;
  logic                   nine_reg;
  wire                    tick    = (cnt_reg == 16'h0000);
  wire [3:0]              last_bit = nine_reg ? 4'h8 : 4'h7;

  assign lnk.busy    = (state_reg != uan_pkg::TX_IDLE);
  assign lnk.tx_line = line_reg;
  assign lnk.tx_done = done_reg;

  // ========================================
  // frame sequencer
  always_ff @(posedge aclk) begin
    done_reg <= 1'b0;
    if (!aresetn) begin
      state_reg <= uan_pkg::TX_IDLE;
      cnt_reg   <= 16'h0000;
      bit_reg   <= 4'h0;
      sh_reg    <= 9'h000;
      line_reg  <= 1'b1;
      nine_reg  <= 1'b0;
    end else begin
      cnt_reg <= tick ? 16'h0000 : cnt_reg - 16'h0001;
      case (state_reg)
        uan_pkg::TX_IDLE: begin
          line_reg <= 1'b1;
          if (lnk.load) begin
            sh_reg    <= lnk.tx_word;
            nine_reg  <= lnk.nine;
            bit_reg   <= 4'h0;
            line_reg  <= 1'b0;
            cnt_reg   <= `UAN_BIT_CYC - 16'h0001;
            state_reg <= uan_pkg::TX_START;
          end
        end
        uan_pkg::TX_START: begin
          if (tick) begin
            line_reg  <= sh_reg[0];
            cnt_reg   <= `UAN_BIT_CYC - 16'h0001;
            state_reg <= uan_pkg::TX_DATA;
          end
        end
        uan_pkg::TX_DATA: begin
          if (tick) begin
            cnt_reg <= `UAN_BIT_CYC - 16'h0001;
            if (bit_reg == last_bit) begin
              line_reg  <= 1'b1;
              state_reg <= uan_pkg::TX_STOP;
            end else begin
              sh_reg   <= {1'b0, sh_reg[8:1]};
              line_reg <= sh_reg[1];
              bit_reg  <= bit_reg + 4'h1;
            end
          end
        end
        uan_pkg::TX_STOP: begin
          if (tick) begin
            done_reg  <= 1'b1;
            state_reg <= uan_pkg::TX_IDLE;
          end
        end
        default: state_reg <= uan_pkg::TX_IDLE;
      endcase
    end
  end

  a_tx_word_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == uan_pkg::TX_IDLE && lnk.load) |=> (sh_reg == $past(lnk.tx_word)))
    else $error("tx shifter did not take the whole word");
endmodule

//--- verilog/uan_rx_engine.sv
/*
  Receive shifter: start bit checked at mid-bit, 8 or 9 data bits lsb
  first, stop bit waited to mid-bit but never sampled; rx_done pulses once per character.
  Assumes rx_line idles high and is synchronous to aclk.
*/
`timescale 1ns/1ps
`include "uan_params.svh"
module uan_rx_engine (
  input wire logic aclk,
  input wire logic aresetn,
  uan_ser_if.rxp   lnk
);
  uan_pkg::uan_rx_state_t state_reg;
  logic [15:0]            cnt_reg;
  logic [3:0]             bit_reg;
  logic [8:0]             sh_reg;
  logic                   nine_reg;
  logic                   done_reg;
  logic [8:0]             word_reg;
  wire                    tick     = (cnt_reg == 16'h0000);
  wire [3:0]              last_bit = nine_reg ? 4'h8 : 4'h7;

  assign lnk.rx_done = done_reg;
  assign lnk.rx_word = word_reg;

  // ========================================
  // frame sampler
  always_ff @(posedge aclk) begin
    done_reg <= 1'b0;
    if (!aresetn) begin
      state_reg <= uan_pkg::RX_IDLE;
      cnt_reg   <= 16'h0000;
      bit_reg   <= 4'h0;
      sh_reg    <= 9'h000;
      nine_reg  <= 1'b0;
      word_reg  <= 9'h000;
    end else begin
      cnt_reg <= tick ? 16'h0000 : cnt_reg - 16'h0001;
      case (state_reg)
        uan_pkg::RX_IDLE: begin
          if (!lnk.rx_line) begin
            nine_reg  <= lnk.nine;
            cnt_reg   <= `UAN_HALF_CYC;
            state_reg <= uan_pkg::RX_START;
          end
        end
        uan_pkg::RX_START: begin
          if (tick) begin
            bit_reg   <= 4'h0;
            cnt_reg   <= `UAN_BIT_CYC - 16'h0001;
            state_reg <= lnk.rx_line ? uan_pkg::RX_IDLE : uan_pkg::RX_DATA;
          end
        end
        uan_pkg::RX_DATA: begin
          if (tick) begin
            sh_reg  <= {lnk.rx_line, sh_reg[8:1]};
            bit_reg <= bit_reg + 4'h1;
            cnt_reg <= `UAN_BIT_CYC - 16'h0001;
            if (bit_reg == last_bit) begin
              state_reg <= uan_pkg::RX_STOP;
            end
          end
        end
        uan_pkg::RX_STOP: begin
          if (tick) begin
            word_reg  <= nine_reg ? sh_reg : {1'b0, sh_reg[8:1]};
            done_reg  <= 1'b1;
            state_reg <= uan_pkg::RX_IDLE;
          end
        end
        default: state_reg <= uan_pkg::RX_IDLE;
      endcase
    end
  end

  a_rx_eight_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_reg && !nine_reg) |-> (word_reg[8] == 1'b0))
    else $error("eight-bit character carried a ninth bit");
endmodule

//--- verilog/uan_ctrl3_top.sv
/*
  Serial ninth-bit and line control: AXI4-Lite register front end, ninth
  data bits, single-wire pin direction, transmit inversion, overrun
  interrupt enable and a small event interrupt block.
  Assumes one clock, synchronous active-low reset, synchronous pins.
*/
`timescale 1ns/1ps
`include "uan_params.svh"
// Summary of operation
// - in nine-bit format the received ninth bit reads in bit 7 of control three.
// - reading the data buffer frees it, so ninth bit and byte may then be replaced.
// - a data write in nine-bit format sends the transmit ninth bit plus the byte.
// - the transmit ninth bit keeps its value across data writes.
// - in single-wire mode bit 5 sets the transmit pin as input (0) or output (1).
// - bit 4 inverts everything driven on the transmit pin, idle included.
// - bit 3 gates the overrun flag onto the interrupt request.
module uan_ctrl3_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic        tx_pin_out,
  output wire logic        tx_pin_oe,
  input  wire logic        tx_pin_in,
  input  wire logic        rx_pin_in,
  output wire logic        irq
);
  uan_ser_if lnk ();

  logic [7:0]  aw_addr_reg;
  logic        aw_hold_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane_reg;
  logic        w_hold_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        tx_ninth_bit_reg;
  logic        single_wire_pin_direction_reg;
  logic        tx_polarity_invert_reg;
  logic        overrun_irq_enable_reg;
  logic [2:0]  cfg_reg;
  logic [7:0]  rx_byte_reg;
  logic        rx_ninth_bit_reg;
  logic        rx_full_reg;
  logic        overrun_reg;
  logic [2:0]  irq_sts_reg;
  logic [2:0]  irq_en_reg;
  logic        pin_out_reg;
  logic        pin_oe_reg;

  // ========================================
  // address decode
  wire [5:0] w_idx     = aw_addr_reg[7:2];
  wire [5:0] r_idx     = s_axi_araddr[7:2];
  wire       wr_do     = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire       wr_en     = wr_do && w_lane_reg;
  wire       rd_do     = s_axi_arvalid && !rvalid_reg;
  wire       wr_c3     = wr_en && (w_idx == `UAN_IDX_C3);
  wire       wr_data   = wr_en && (w_idx == `UAN_IDX_DATA);
  wire       wr_cfg    = wr_en && (w_idx == `UAN_IDX_CFG);
  wire       wr_en_irq = wr_en && (w_idx == `UAN_IDX_IRQ_EN);
  wire       wr_clr    = wr_en && (w_idx == `UAN_IDX_IRQ_CLR);
  wire       rd_data   = rd_do && (r_idx == `UAN_IDX_DATA);
  wire       w_known   = (w_idx >= `UAN_IDX_C3) && (w_idx <= `UAN_IDX_IRQ_CLR);
  wire       r_known   = (r_idx >= `UAN_IDX_C3) && (r_idx <= `UAN_IDX_IRQ_CLR);
  wire       nine_bit  = cfg_reg[`UAN_CFG_NINE];
  wire       loop_mode_select      = cfg_reg[`UAN_CFG_LOOP];
  wire       receiver_source_select = cfg_reg[`UAN_CFG_RECEIVER_SOURCE_SELECT];
  wire       single_wire = loop_mode_select && receiver_source_select;

  wire       rx9_view  = nine_bit && rx_ninth_bit_reg;
  wire [7:0] c3_view   = {rx9_view, tx_ninth_bit_reg, single_wire_pin_direction_reg,
                          tx_polarity_invert_reg, overrun_irq_enable_reg, 3'h0};
  wire [7:0] rd_val;
  assign rd_val = (r_idx == `UAN_IDX_C3)      ? c3_view :
                  (r_idx == `UAN_IDX_DATA)    ? rx_byte_reg :
                  (r_idx == `UAN_IDX_CFG)     ? {5'h00, cfg_reg} :
                  (r_idx == `UAN_IDX_STAT)    ? {5'h00, lnk.busy, overrun_reg, rx_full_reg} :
                  (r_idx == `UAN_IDX_IRQ_STS) ? {5'h00, irq_sts_reg} :
                  (r_idx == `UAN_IDX_IRQ_EN)  ? {5'h00, irq_en_reg} : 8'h00;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ========================================
  // bus handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `UAN_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `UAN_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= w_known ? `UAN_RESP_OKAY : `UAN_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_do) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= {24'h000000, rd_val};
        rresp_reg  <= r_known ? `UAN_RESP_OKAY : `UAN_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ========================================
  // control registers
  wire [7:0] c3_rst = `UAN_C3_RST;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {tx_ninth_bit_reg, single_wire_pin_direction_reg, tx_polarity_invert_reg,
       overrun_irq_enable_reg} <= c3_rst[`UAN_C3_TX9:`UAN_C3_OVERRUN_IRQ_ENABLE];
      cfg_reg    <= `UAN_CFG_RST;
      irq_en_reg <= 3'h0;
    end else begin
      if (wr_c3) begin
        tx_ninth_bit_reg              <= w_data_reg[`UAN_C3_TX9];
        single_wire_pin_direction_reg <= w_data_reg[`UAN_C3_DIR];
        tx_polarity_invert_reg        <= w_data_reg[`UAN_C3_INV];
        overrun_irq_enable_reg        <= w_data_reg[`UAN_C3_OVERRUN_IRQ_ENABLE];
      end
      if (wr_cfg) begin
        cfg_reg <= w_data_reg[2:0];
      end
      if (wr_en_irq) begin
        irq_en_reg <= w_data_reg[2:0];
      end
    end
  end

  // ========================================
  // transmit path
  // ninth bit joins byte
  assign lnk.load    = wr_data;
  assign lnk.tx_word = {nine_bit && tx_ninth_bit_reg, w_data_reg};
  assign lnk.nine    = nine_bit;

  // ========================================
  // receive buffer
  // data read frees buffer
  wire rx_take = lnk.rx_done && (!rx_full_reg || rd_data);
  assign lnk.rx_line = single_wire      ? tx_pin_in :
                       loop_mode_select ? lnk.tx_line : rx_pin_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte_reg      <= 8'h00;
      rx_ninth_bit_reg <= 1'b0;
      rx_full_reg      <= 1'b0;
      overrun_reg      <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_byte_reg      <= lnk.rx_word[7:0];
        rx_ninth_bit_reg <= lnk.rx_word[8];
      end
      rx_full_reg <= rx_take || (rx_full_reg && !rd_data);
      overrun_reg <= (lnk.rx_done && !rx_take) || (overrun_reg && !rd_data);
    end
  end

  // ========================================
  // interrupts
  wire [2:0] irq_ev = {lnk.tx_done, lnk.rx_done && !rx_take, rx_take};
  wire [2:0] irq_clr = wr_clr ? w_data_reg[2:0] : 3'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_reg <= 3'h0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_ev;
    end
  end
  assign irq = (|(irq_sts_reg & irq_en_reg)) || (overrun_reg && overrun_irq_enable_reg);

  // ========================================
  // transmit pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= 1'b1;
      pin_oe_reg  <= 1'b1;
    end else begin
      pin_out_reg <= lnk.tx_line ^ tx_polarity_invert_reg;
      pin_oe_reg  <= single_wire ? single_wire_pin_direction_reg : 1'b1;
    end
  end
  assign tx_pin_out = pin_out_reg;
  assign tx_pin_oe  = pin_oe_reg;

  uan_tx_engine u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lnk     (lnk.txp)
  );
  uan_rx_engine u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lnk     (lnk.rxp)
  );

  // ========================================
  // checks
  a_rx_ninth_view: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_take && nine_bit && !wr_cfg) |=> (c3_view[7] == $past(lnk.rx_word[8])))
    else $error("received ninth bit not shown in bit 7");
  a_data_read_frees: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_data && !lnk.rx_done) |=> !rx_full_reg && !overrun_reg)
    else $error("data read did not free the buffer");
  a_tx_word_sent: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && nine_bit) |-> (lnk.tx_word[8] == tx_ninth_bit_reg))
    else $error("tx ninth bit missing from loaded word");
  a_tx9_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wr_c3 && wr_data) |=> $stable(tx_ninth_bit_reg))
    else $error("tx ninth bit changed on a data write");
  a_pin_direction: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 $past(single_wire) |-> (tx_pin_oe == $past(single_wire_pin_direction_reg)))
    else $error("single-wire pin direction wrong");
  a_idle_inverted: assert property (@(posedge aclk) disable iff (!aresetn)
    (!lnk.busy && $past(!lnk.busy) && $past(tx_polarity_invert_reg))
    |-> (tx_pin_out == 1'b0))
    else $error("inverted idle level not low");
  a_overrun_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    (overrun_reg && overrun_irq_enable_reg) |-> irq)
    else $error("enabled overrun raised no interrupt");
  a_eight_bit_rx9: assert property (@(posedge aclk) disable iff (!aresetn)
    !nine_bit |-> (c3_view[7] == 1'b0))
    else $error("ninth bit visible in eight-bit format");
  a_rx_buf_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_full_reg && !rd_data)
    |=> ($stable(rx_ninth_bit_reg) && $stable(rx_byte_reg)))
    else $error("unread character overwritten");
  a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (lnk.rx_done && rx_full_reg && !rd_data)
    |=> overrun_reg)
    else $error("refused character set no overrun");
  a_tx9_written: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_c3
    |=> (tx_ninth_bit_reg == $past(w_data_reg[`UAN_C3_TX9])))
    else $error("tx ninth bit write lost");
  a_oe_outside_single: assert property (@(posedge aclk) disable iff (!aresetn)
    !single_wire
    |=> tx_pin_oe)
    else $error("pin not driven outside single-wire mode");
  a_idle_plain: assert property (@(posedge aclk) disable iff (!aresetn)
    (!lnk.busy && $past(!lnk.busy) && !$past(tx_polarity_invert_reg))
    |-> tx_pin_out)
    else $error("plain idle level not high");
  a_overrun_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!overrun_irq_enable_reg && ((irq_sts_reg & irq_en_reg) == 3'h0))
    |-> !irq)
    else $error("masked overrun raised an interrupt");
endmodule

//--- dv/uan_remote_model.sv
/*
  Remote serial device: sends characters on the receive pin and decodes
  characters seen on the transmit wire.
  Assumes the bench clock and the bit time of the block.
*/
`timescale 1ns/1ps
`include "uan_params.svh"
module uan_remote_model (
  input  wire logic aclk,
  input  wire logic line_in,
  output var  logic line_out
);
  initial line_out = 1'b1;

  // ========================================
  // send start, nbits data lsb first, one stop
  task automatic send_char(input logic [8:0] word, input int nbits);
    @(posedge aclk);
    line_out <= 1'b0;
    repeat (`UAN_BIT_CYC) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= word[i];
      repeat (`UAN_BIT_CYC) @(posedge aclk);
    end
    line_out <= 1'b1;
    repeat (`UAN_BIT_CYC) @(posedge aclk);
  endtask

  // ========================================
  // capture data bits and the stop bit at mid-bit
  task automatic get_char(input int nbits, input logic inv, output logic [9:0] frame);
    int n;
    n = 0;
    frame = 10'h000;
    while ((line_in ^ inv) !== 1'b0 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    repeat (`UAN_HALF_CYC) @(posedge aclk);
    for (int i = 0; i <= nbits; i++) begin
      repeat (`UAN_BIT_CYC) @(posedge aclk);
      frame[i] = line_in ^ inv;
    end
  endtask
endmodule

//--- dv/test_uan_ctrl3_top.sv
/*
  Bench for the ninth-bit and line control block: AXI4-Lite tasks and a
  remote serial device, tests as call sequences with expected values.
  Assumes the design files and the remote model are compiled first.
*/
`timescale 1ns/1ps
`include "uan_params.svh"
module test_uan_ctrl3_top;
  localparam logic [7:0] adr_c3   = {`UAN_IDX_C3, 2'b00};
  localparam logic [7:0] adr_data = {`UAN_IDX_DATA, 2'b00};
  localparam logic [7:0] adr_cfg  = {`UAN_IDX_CFG, 2'b00};
  localparam logic [7:0] adr_stat = {`UAN_IDX_STAT, 2'b00};
  localparam logic [7:0] adr_ists = {`UAN_IDX_IRQ_STS, 2'b00};
  localparam logic [7:0] adr_ien  = {`UAN_IDX_IRQ_EN, 2'b00};
  localparam logic [7:0] adr_iclr = {`UAN_IDX_IRQ_CLR, 2'b00};

  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h00000000;
  logic [3:0]  wstrb     = 4'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic [7:0]  araddr    = 8'h00;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         pin_out, pin_oe, pin_wire, rx_line, irq;
  logic [31:0] rd_data;
  logic [1:0]  resp_seen;
  int          fails       = 0;
  int          check_count = 0;

  always #12.5 aclk = ~aclk;
  // single-wire pin pulled up while nobody drives it
  assign pin_wire = pin_oe ? pin_out : 1'b1;

  uan_ctrl3_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_pin_out(pin_out), .tx_pin_oe(pin_oe),
    .tx_pin_in(pin_wire), .rx_pin_in(rx_line), .irq(irq));

  uan_remote_model remote (.aclk(aclk), .line_in(pin_wire), .line_out(rx_line));

  // ========================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ========================================
  // bus tasks; ready sampled at the falling edge, handshake at the rising
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    logic aw_go, w_go, b_go;
    int   n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_go = 1'b0;
    n = 0;
    while (!b_go && n < 200) begin
      @(negedge aclk);
      aw_go = awvalid && (awready === 1'b1);
      w_go = wvalid && (wready === 1'b1);
      b_go = (bvalid === 1'b1);
      resp_seen = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_go) fails++;
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic a_go, r_go;
    int   n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_go = 1'b0;
    n = 0;
    while (!r_go && n < 200) begin
      @(negedge aclk);
      a_go = arvalid && (arready === 1'b1);
      r_go = (rvalid === 1'b1);
      rd_data = rdata;
      resp_seen = rresp;
      @(posedge aclk);
      if (a_go) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_go) fails++;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    axi_read(a);
    check(what, {24'h000000, exp}, rd_data);
  endtask

  task automatic look(input string what, input logic exp, input logic got);
    check(what, {31'h0, exp}, {31'h0, got});
  endtask

  // write one character, decode it on the wire, wait for the shifter to go idle
  task automatic tx_char(input logic [7:0] d, input int nbits, input logic inv,
                         input logic [9:0] exp);
    logic [9:0] frame;
    int         n;
    axi_write(adr_data, d);
    remote.get_char(nbits, inv, frame);
    check("tx frame", {22'h0, exp}, {22'h0, frame});
    n = 0;
    rd_data = 32'hFFFFFFFF;
    while (rd_data[2] !== 1'b0 && n < 500) begin
      axi_read(adr_stat);
      n++;
    end
    check("tx idle", 32'h0, {31'h0, rd_data[2]});
  endtask

  // ========================================
  // tests
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("c3 reset", adr_c3, 8'h00);
    @(negedge aclk);
    look("pin idle", 1'b1, pin_out);
    look("oe normal", 1'b1, pin_oe);
    axi_read(8'h3C);
    check("unmapped read", {30'h0, `UAN_RESP_SLVERR}, {30'h0, resp_seen});
    axi_write(8'h34, 8'hFF);
    check("unmapped write", {30'h0, `UAN_RESP_SLVERR}, {30'h0, resp_seen});
    axi_write(adr_c3, 8'hFF);
    rd_chk("c3 fields", adr_c3, 8'h78);
    @(negedge aclk);
    look("pin idle inverted", 1'b0, pin_out);
    look("irq no overrun", 1'b0, irq);
    axi_write(adr_c3, 8'h00);
    axi_write(adr_cfg, 8'h06);
    @(negedge aclk);
    look("pin restored", 1'b1, pin_out);
    look("single wire input", 1'b0, pin_oe);
    axi_write(adr_c3, 8'h20);
    @(negedge aclk);
    look("single wire output", 1'b1, pin_oe);
    axi_write(adr_cfg, 8'h01);
    axi_write(adr_c3, 8'h40);
    tx_char(8'hA5, 9, 1'b0, 10'h3A5);
    tx_char(8'h3C, 9, 1'b0, 10'h33C);
    axi_write(adr_c3, 8'h00);
    tx_char(8'hC3, 9, 1'b0, 10'h2C3);
    axi_write(adr_cfg, 8'h00);
    axi_write(adr_c3, 8'h10);
    tx_char(8'h5A, 8, 1'b1, 10'h15A);
    axi_write(adr_c3, 8'h00);
    axi_write(adr_cfg, 8'h01);
    remote.send_char(9'h1C3, 9);
    rd_chk("rx ninth set", adr_c3, 8'h80);
    rd_chk("rx byte", adr_data, 8'hC3);
    remote.send_char(9'h055, 9);
    rd_chk("rx ninth replaced", adr_c3, 8'h00);
    remote.send_char(9'h1FF, 9);
    rd_chk("overrun status", adr_stat, 8'h03);
    @(negedge aclk);
    look("irq overrun masked", 1'b0, irq);
    axi_write(adr_c3, 8'h08);
    @(negedge aclk);
    look("irq overrun", 1'b1, irq);
    rd_chk("rx byte kept", adr_data, 8'h55);
    @(negedge aclk);
    look("irq overrun cleared", 1'b0, irq);
    rd_chk("irq sticky", adr_ists, 8'h07);
    axi_write(adr_ien, 8'h01);
    @(negedge aclk);
    look("irq enabled", 1'b1, irq);
    axi_write(adr_iclr, 8'h07);
    rd_chk("irq cleared", adr_ists, 8'h00);
    @(negedge aclk);
    look("irq low", 1'b0, irq);
    axi_write(adr_ien, 8'h00);
    axi_write(adr_cfg, 8'h00);
    remote.send_char(9'h081, 8);
    rd_chk("eight bit ninth", adr_c3, 8'h08);
    rd_chk("eight bit byte", adr_data, 8'h81);
    axi_write(adr_cfg, 8'h03);
    axi_write(adr_c3, 8'h40);
    tx_char(8'h96, 9, 1'b0, 10'h396);
    rd_chk("loop ninth", adr_c3, 8'hC0);
    rd_chk("loop byte", adr_data, 8'h96);
    finish_test();
  end

  // ========================================
  // watchdog, well beyond the nine frames of the tests
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule
